// *** hw/hdlc_fifo_threshold_and_test_status.sv ***
// HDLC FIFO level selection, status, interrupt flags and diagnostic status
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_fifo_defines.svh"
module hdlc_fifo_threshold_and_test_status
	import hdlc_fifo_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire bus_req_t bus_req_i,
	output logic [7:0] bus_rdata_o,
	input wire fifo_evt_t rx_evt_i,
	input wire fifo_evt_t tx_evt_i,
	input wire logic rx_flag_seen_i,
	input wire logic receiver_enable_bit_i,
	input wire logic transmitter_enable_bit_i,
	input wire logic rx_bit_clock_probe_i,
	input wire logic tx_bit_clock_probe_i,
	input wire logic crc_ok_i,
	input wire logic addr_match_i,
	output logic [1:0] rx_fifo_state_o,
	output logic tx_fifo_full_o,
	output logic rx_fifo_full_o,
	output logic rx_write_accept_o,
	output logic rx_fill_irq_flag_o,
	output logic tx_drain_irq_flag_o,
	output logic rx_overrun_flag_o
);
	ctl_state_t st_q;
	ctl_state_t st_d;
	fifo_evt_t rx_evt;
	logic [`CNT_W-1:0] rx_count;
	logic [`CNT_W-1:0] tx_count;
	logic rx_full;
	logic rx_empty;
	logic tx_empty;
	logic [`SEL_W-1:0] rx_full_level_sel;
	logic [`SEL_W-1:0] tx_full_level_sel;
	logic [`SEL_W-1:0] rx_full_irq_sel;
	logic [`SEL_W-1:0] tx_low_irq_sel;
	logic [`CNT_W-1:0] rx_full_level;
	logic [`CNT_W-1:0] tx_full_level;
	logic [`CNT_W-1:0] rx_irq_level;
	logic [`CNT_W-1:0] tx_irq_level;
	logic [7:0] diag;
	logic [7:0] irq_status;
	logic rx_overrun_evt;
	logic rx_fill_evt;
	logic tx_drain_evt;
	logic rd_acc;
	logic wr_acc;
	logic irq_read;
	logic rx_fifo_state_hi;
	logic rx_fifo_state_lo;

	assign rx_full_level_sel = st_q.level_sel[`RX_SEL_LSB +: `SEL_W];
	assign tx_full_level_sel = st_q.level_sel[`TX_SEL_LSB +: `SEL_W];
	assign rx_full_irq_sel = st_q.thresh_sel[`RX_SEL_LSB +: `SEL_W];
	assign tx_low_irq_sel = st_q.thresh_sel[`TX_SEL_LSB +: `SEL_W];
	assign rx_full_level = (8'({5'h00, rx_full_level_sel}) + 8'h01) * `FULL_LEVEL_STEP;
	assign tx_full_level = (8'({5'h00, tx_full_level_sel}) + 8'h01) * `FULL_LEVEL_STEP;
	assign rx_irq_level = `RX_IRQ_BASE + 8'({5'h00, rx_full_irq_sel}) * `IRQ_STEP;
	assign tx_irq_level = `TX_IRQ_BASE + 8'({5'h00, tx_low_irq_sel}) * `IRQ_STEP;

	// Receive writes are refused while the receiver is blocked after an overrun
	assign rx_write_accept_o = ~st_q.rx_blocked;
	assign rx_evt.push = rx_evt_i.push & ~st_q.rx_blocked;
	assign rx_evt.pop = rx_evt_i.pop;

	fifo_occupancy u_rx_occ (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.evt_i(rx_evt),
		.count_o(rx_count),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	fifo_occupancy u_tx_occ (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.evt_i(tx_evt_i),
		.count_o(tx_count),
		.full_o(),
		.empty_o(tx_empty)
	);

	assign rx_overrun_evt = rx_evt.push & ~rx_evt.pop & rx_full;
	// Crossing events use the count before the change, so each crossing fires once
	assign rx_fill_evt = rx_evt.push & ~rx_evt.pop & ~rx_full & (rx_count == rx_irq_level);
	assign tx_drain_evt = tx_evt_i.pop & ~tx_evt_i.push & ~tx_empty & (tx_count == tx_irq_level);

	assign rx_fifo_state_hi = (rx_count >= rx_full_level) | (rx_count >= rx_irq_level);
	assign rx_fifo_state_lo = ~rx_empty & ((rx_count >= rx_irq_level) | (rx_count < rx_full_level));
	assign rx_fifo_state_o = {rx_fifo_state_hi, rx_fifo_state_lo};
	assign rx_fifo_full_o = rx_fifo_state_hi;
	assign tx_fifo_full_o = (tx_count >= tx_full_level);

	assign diag = {4'h0,
		rx_bit_clock_probe_i & receiver_enable_bit_i,
		tx_bit_clock_probe_i & transmitter_enable_bit_i,
		crc_ok_i,
		addr_match_i};
	assign irq_status = {4'h0, st_q.tx_drain_irq_flag, 1'b0, st_q.rx_fill_irq_flag,
		st_q.rx_overrun_flag};

	assign rd_acc = bus_req_i.cs & bus_req_i.rd;
	assign wr_acc = bus_req_i.cs & bus_req_i.wr & ~bus_req_i.rd;
	assign irq_read = rd_acc & (bus_req_i.addr == `OFS_IRQ_STATUS);

	always_comb begin
		st_d = st_q;
		if (wr_acc && bus_req_i.addr == `OFS_LEVEL_SEL) begin
			st_d.level_sel = bus_req_i.wdata & `SEL_REG_MASK;
		end
		if (wr_acc && bus_req_i.addr == `OFS_THRESH_SEL) begin
			st_d.thresh_sel = bus_req_i.wdata & `SEL_REG_MASK;
		end
		if (rd_acc) begin
			unique case (bus_req_i.addr)
				`OFS_IRQ_STATUS: st_d.rdata = irq_status;
				`OFS_DIAG_STATUS: st_d.rdata = diag;
				`OFS_LEVEL_SEL: st_d.rdata = st_q.level_sel;
				`OFS_THRESH_SEL: st_d.rdata = st_q.thresh_sel;
				default: st_d.rdata = 8'h00;
			endcase
		end
		// A set in the same cycle as the clearing read wins
		st_d.rx_fill_irq_flag = rx_fill_evt | (st_q.rx_fill_irq_flag & ~irq_read);
		st_d.tx_drain_irq_flag = tx_drain_evt | (st_q.tx_drain_irq_flag & ~irq_read);
		st_d.rx_overrun_flag = rx_overrun_evt | (st_q.rx_overrun_flag & ~irq_read);
		st_d.rx_blocked = rx_overrun_evt | (st_q.rx_blocked & ~rx_flag_seen_i);
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus_rdata_o = st_q.rdata;
	assign rx_fill_irq_flag_o = st_q.rx_fill_irq_flag;
	assign tx_drain_irq_flag_o = st_q.tx_drain_irq_flag;
	assign rx_overrun_flag_o = st_q.rx_overrun_flag;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	diag_read_a: assert property (
		rd_acc && bus_req_i.addr == `OFS_DIAG_STATUS |=> bus_rdata_o == $past(diag) &&
		bus_rdata_o[3] == ($past(rx_bit_clock_probe_i) & $past(receiver_enable_bit_i)))
		else $error("diagnostic read data wrong");
	diag_rsv_a: assert property (
		rd_acc && bus_req_i.addr == `OFS_DIAG_STATUS |=> bus_rdata_o[7:4] == 4'h0 &&
		bus_rdata_o[1:0] == {$past(crc_ok_i), $past(addr_match_i)})
		else $error("diagnostic reserved or status bits wrong");
	sel_mask_a: assert property (
		wr_acc && bus_req_i.addr == `OFS_LEVEL_SEL |=> st_q.level_sel[7] == 1'b0 &&
		st_q.level_sel[3] == 1'b0 && st_q.level_sel[6:4] == $past(bus_req_i.wdata[6:4]))
		else $error("level select write wrong");
	rx_state_a: assert property (
		(rx_empty -> rx_fifo_state_o == `RX_ST_EMPTY) &&
		(rx_count >= rx_irq_level -> rx_fifo_state_o == `RX_ST_IRQ))
		else $error("receive state field wrong");
	tx_full_a: assert property (
		tx_fifo_full_o == (tx_count >= 8'({5'h00, tx_full_level_sel}) * 8'h10 + 8'h10))
		else $error("transmit full status wrong");
	rx_fill_set_a: assert property (
		rx_evt.push && !rx_evt.pop && rx_count == rx_irq_level && !rx_full
		|=> rx_fill_irq_flag_o && rx_count == $past(rx_count) + 8'h01)
		else $error("receive fill flag not set");
	tx_drain_set_a: assert property (
		tx_evt_i.pop && !tx_evt_i.push && tx_count == 8'h08 + 8'({5'h00, tx_low_irq_sel}) * 8'h08
		|=> tx_drain_irq_flag_o)
		else $error("transmit drain flag not set");
	irq_clear_a: assert property (
		irq_read && !rx_fill_evt && !tx_drain_evt && !rx_overrun_evt
		|=> !rx_fill_irq_flag_o && !tx_drain_irq_flag_o && !rx_overrun_flag_o)
		else $error("status read did not clear flags");
	overrun_a: assert property (
		rx_evt_i.push && !rx_evt_i.pop && rx_count == 8'h80 && rx_write_accept_o
		|=> rx_overrun_flag_o && !rx_write_accept_o && rx_count == 8'h80)
		else $error("overrun not handled");
	count_track_a: assert property (
		rx_evt.push && !rx_evt.pop && !rx_full |=> rx_count == $past(rx_count) + 8'h01)
		else $error("receive count did not follow write");
	count_pop_a: assert property (
		rx_evt.pop && !rx_evt.push && !rx_empty |=> rx_count == $past(rx_count) - 8'h01)
		else $error("receive count did not follow read");
	diag_tx_bit_clock_probe_a: assert property (
		rd_acc && bus_req_i.addr == `OFS_DIAG_STATUS |=>
		bus_rdata_o[2] == ($past(tx_bit_clock_probe_i) & $past(transmitter_enable_bit_i)))
		else $error("transmit clock probe bit wrong");
	thr_mask_a: assert property (
		wr_acc && bus_req_i.addr == `OFS_THRESH_SEL |=> st_q.thresh_sel[7] == 1'b0 &&
		st_q.thresh_sel[3] == 1'b0 && st_q.thresh_sel[2:0] == $past(bus_req_i.wdata[2:0]))
		else $error("threshold select write wrong");
	rx_level_a: assert property (
		rx_count >= 8'({5'h00, rx_full_level_sel}) * 8'h10 + 8'h10 && rx_count < rx_irq_level
		|-> rx_fifo_state_o == `RX_ST_FULL)
		else $error("receive full status level wrong");
	rx_irq_lvl_a: assert property (
		rx_count >= 8'h40 + 8'({5'h00, rx_full_irq_sel}) * 8'h08 |-> rx_fifo_state_o == `RX_ST_IRQ)
		else $error("receive interrupt level wrong");
	rx_fill_quiet_a: assert property (
		!(rx_evt.push && !rx_evt.pop && !rx_full &&
		rx_count == 8'h40 + 8'({5'h00, rx_full_irq_sel}) * 8'h08) && !rx_fill_irq_flag_o
		|=> !rx_fill_irq_flag_o)
		else $error("receive fill flag set without crossing");
	tx_drain_quiet_a: assert property (
		!(tx_evt_i.pop && tx_count == 8'h08 + 8'({5'h00, tx_low_irq_sel}) * 8'h08) &&
		!tx_drain_irq_flag_o |=> !tx_drain_irq_flag_o)
		else $error("transmit drain flag set without crossing");
	unblock_a: assert property (
		rx_flag_seen_i && !rx_overrun_evt |=> rx_write_accept_o)
		else $error("receiver not re-enabled by flag");

	fill_cov: cover property (rx_fill_evt ##[1:20] irq_read);
	overrun_cov: cover property (rx_overrun_evt ##[1:50] rx_flag_seen_i);
	drain_cov: cover property (tx_drain_evt);
	diag_cov: cover property (rd_acc && bus_req_i.addr == `OFS_DIAG_STATUS);
endmodule : hdlc_fifo_threshold_and_test_status
`default_nettype wire

// *** hw/hdlc_fifo_defines.svh ***
// Offsets, field positions, levels and reset values of the HDLC FIFO status block
`ifndef HDLC_FIFO_DEFINES_SVH
`define HDLC_FIFO_DEFINES_SVH
`define ADDR_W 5
`define OFS_IRQ_STATUS 5'h17
`define OFS_DIAG_STATUS 5'h1C
`define OFS_LEVEL_SEL 5'h1D
`define OFS_THRESH_SEL 5'h1E
`define RX_SEL_LSB 4
`define TX_SEL_LSB 0
`define SEL_W 3
`define SEL_REG_MASK 8'h77
`define SEL_REG_RESET 8'h00
`define DIAG_RX_CLK_BIT 3
`define DIAG_TX_CLK_BIT 2
`define DIAG_CRC_BIT 1
`define DIAG_ADDR_BIT 0
`define IRQ_TX_LOW_BIT 3
`define IRQ_RX_FULL_BIT 1
`define IRQ_RX_OVFL_BIT 0
`define FIFO_DEPTH 8'h80
`define CNT_W 8
`define FULL_LEVEL_STEP 8'h10
`define RX_IRQ_BASE 8'h40
`define TX_IRQ_BASE 8'h08
`define IRQ_STEP 8'h08
`define RX_ST_EMPTY 2'h0
`define RX_ST_BELOW 2'h1
`define RX_ST_FULL 2'h2
`define RX_ST_IRQ 2'h3
`endif

// *** hw/hdlc_fifo_pkg.sv ***
// Types shared by the HDLC FIFO status block
`include "hdlc_fifo_defines.svh"
package hdlc_fifo_pkg;
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [`ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic push;
		logic pop;
	} fifo_evt_t;

	typedef struct packed {
		logic [`CNT_W-1:0] count;
	} occ_state_t;

	typedef struct packed {
		logic [7:0] level_sel;
		logic [7:0] thresh_sel;
		logic [7:0] rdata;
		logic rx_fill_irq_flag;
		logic tx_drain_irq_flag;
		logic rx_overrun_flag;
		logic rx_blocked;
	} ctl_state_t;
endpackage : hdlc_fifo_pkg

// *** hw/fifo_occupancy.sv ***
// Byte occupancy counter for one 128-byte FIFO
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_fifo_defines.svh"
module fifo_occupancy
	import hdlc_fifo_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire fifo_evt_t evt_i,
	output logic [`CNT_W-1:0] count_o,
	output logic full_o,
	output logic empty_o
);
	occ_state_t st_q;
	occ_state_t st_d;
	logic do_push;
	logic do_pop;

	assign full_o = (st_q.count == `FIFO_DEPTH);
	assign empty_o = (st_q.count == 8'h00);
	assign count_o = st_q.count;
	// Pushes on a full FIFO and pops on an empty one are dropped
	assign do_push = evt_i.push & ~full_o;
	assign do_pop = evt_i.pop & ~empty_o;

	always_comb begin
		st_d = st_q;
		if (do_push && !do_pop) begin
			st_d.count = st_q.count + 8'h01;
		end else if (do_pop && !do_push) begin
			st_d.count = st_q.count - 8'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : fifo_occupancy
`default_nettype wire

// *** test/host_cpu_model.sv ***
// Host processor model issuing register cycles on the block's parallel bus
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_fifo_defines.svh"
module host_cpu_model
	import hdlc_fifo_pkg::*;
(
	input wire logic mclk_i,
	output var bus_req_t bus_req_o,
	input wire logic [7:0] bus_rdata_i
);
	initial bus_req_o = '0;

	// One strobe cycle, then idle with address and data inverted so nothing stale looks valid
	task automatic cycle(input logic rd, input logic [`ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		bus_req_o <= '{cs: 1'b1, rd: rd, wr: !rd, addr: a, wdata: d};
		@(negedge mclk_i);
		bus_req_o <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : cycle

	task automatic reg_wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
		cycle(1'b0, a, d);
	endtask : reg_wr

	task automatic reg_rd(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
		cycle(1'b1, a, 8'h00);
		d = bus_rdata_i;
	endtask : reg_rd
endmodule : host_cpu_model
`default_nettype wire

// *** test/hdlc_fifo_threshold_and_test_status_tb.sv ***
// Self-checking bench for the HDLC FIFO level, threshold and diagnostic block
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_fifo_defines.svh"
module hdlc_fifo_threshold_and_test_status_tb
	import hdlc_fifo_pkg::*;
;
	logic mclk_i, rst_b_i, flag_seen, receiver_enable_bit, transmitter_enable_bit, rx_bit_clock_probe, tx_bit_clock_probe, crc_ok, addr_m;
	logic tx_full, rx_full, accept, fill_f, drain_f, ovr_f;
	logic [1:0] rx_state;
	logic [7:0] rdata;
	bus_req_t bus_req;
	fifo_evt_t rx_evt, tx_evt;
	int err_total, n_checks, n, k;

	hdlc_fifo_threshold_and_test_status hdlc_fifo_threshold_and_test_status_i (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req), .bus_rdata_o(rdata),
		.rx_evt_i(rx_evt), .tx_evt_i(tx_evt), .rx_flag_seen_i(flag_seen),
		.receiver_enable_bit_i(receiver_enable_bit), .transmitter_enable_bit_i(transmitter_enable_bit),
		.rx_bit_clock_probe_i(rx_bit_clock_probe), .tx_bit_clock_probe_i(tx_bit_clock_probe), .crc_ok_i(crc_ok),
		.addr_match_i(addr_m), .rx_fifo_state_o(rx_state), .tx_fifo_full_o(tx_full),
		.rx_fifo_full_o(rx_full), .rx_write_accept_o(accept), .rx_fill_irq_flag_o(fill_f),
		.tx_drain_irq_flag_o(drain_f), .rx_overrun_flag_o(ovr_f));
	host_cpu_model host_cpu_model_i (.mclk_i(mclk_i), .bus_req_o(bus_req), .bus_rdata_i(rdata));

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pin

	task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		host_cpu_model_i.reg_rd(a, d);
		chk_reg(nm, e, d);
	endtask : rd_chk

	// One byte event on each FIFO, held for exactly one clock
	task automatic pulse(input fifo_evt_t r, input fifo_evt_t t);
		@(negedge mclk_i);
		rx_evt = r;
		tx_evt = t;
		@(negedge mclk_i);
		rx_evt = '0;
		tx_evt = '0;
	endtask : pulse

	task automatic flag_pulse();
		@(negedge mclk_i);
		flag_seen = 1'b1;
		@(negedge mclk_i);
		flag_seen = 1'b0;
	endtask : flag_pulse

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		give_verdict();
	end

	initial begin
		{rx_bit_clock_probe, receiver_enable_bit, tx_bit_clock_probe, transmitter_enable_bit, crc_ok, addr_m, flag_seen} = '0;
		rx_evt = '0;
		tx_evt = '0;
		rst_b_i = 1'b0;
		repeat (20) @(negedge mclk_i);
		rst_b_i = 1'b1;
		chk_pin("rx_state", 2'h0, rx_state);
		rd_chk(`OFS_LEVEL_SEL, 8'h00, "level_sel");
		rd_chk(`OFS_THRESH_SEL, 8'h00, "thresh_sel");
		host_cpu_model_i.reg_wr(`OFS_LEVEL_SEL, 8'hFF);
		rd_chk(`OFS_LEVEL_SEL, 8'h77, "level_mask");
		host_cpu_model_i.reg_wr(`OFS_THRESH_SEL, 8'h88);
		rd_chk(`OFS_THRESH_SEL, 8'h00, "thresh_mask");
		host_cpu_model_i.reg_wr(`OFS_DIAG_STATUS, 8'hFF);
		rd_chk(5'h05, 8'h00, "unmapped");
		for (n = 0; n < 64; n++) begin
			{rx_bit_clock_probe, receiver_enable_bit, tx_bit_clock_probe, transmitter_enable_bit, crc_ok, addr_m} = n[5:0];
			rd_chk(`OFS_DIAG_STATUS, {4'h0, n[5] & n[4], n[3] & n[2], n[1:0]}, "diag");
		end
		$display("test regs done");
		host_cpu_model_i.reg_wr(`OFS_THRESH_SEL, 8'h70);
		for (n = 1; n <= 128; n++) begin
			pulse(2'b10, 2'b10);
			if (n == 120 || n == 121)
				chk_pin("fill_flag", {1'b0, n == 121}, {1'b0, fill_f});
			if (n % 16 == 0) begin
				k = n / 16 - 1;
				host_cpu_model_i.reg_wr(`OFS_LEVEL_SEL, {1'b0, k[2:0], 1'b0, k[2:0]});
				chk_pin("state_full", n >= 120 ? 2'h3 : 2'h2, rx_state);
				chk_pin("tx_full", 2'h1, {1'b0, tx_full});
				chk_pin("rx_full_pin", 2'h1, {1'b0, rx_full});
				if (k < 7) begin
					k++;
					host_cpu_model_i.reg_wr(`OFS_LEVEL_SEL, {1'b0, k[2:0], 1'b0, k[2:0]});
					chk_pin("state_below", 2'h1, rx_state);
					chk_pin("tx_not_full", 2'h0, {1'b0, tx_full});
					chk_pin("rx_not_full", 2'h0, {1'b0, rx_full});
				end
			end
		end
		pulse(2'b10, 2'b00);
		chk_pin("overrun", 2'h2, {ovr_f, accept});
		rd_chk(`OFS_IRQ_STATUS, 8'h03, "irq_fill_ovfl");
		rd_chk(`OFS_IRQ_STATUS, 8'h00, "irq_cleared");
		pulse(2'b01, 2'b00);
		pulse(2'b10, 2'b00);
		flag_pulse();
		chk_pin("unblocked", 2'h1, {1'b0, accept});
		pulse(2'b10, 2'b00);
		chk_pin("no_overrun", 2'h0, {1'b0, ovr_f});
		pulse(2'b10, 2'b00);
		rd_chk(`OFS_IRQ_STATUS, 8'h01, "irq_ovfl");
		$display("test fill done");
		for (n = 127; n >= 0; n--) begin
			pulse(2'b01, 2'b00);
			if (n >= 64 && n <= 120 && n % 8 == 0) begin
				k = (n - 64) / 8;
				host_cpu_model_i.reg_wr(`OFS_THRESH_SEL, {1'b0, k[2:0], 4'h7});
				chk_pin("state_irq", 2'h3, rx_state);
				if (k < 7) begin
					k++;
					host_cpu_model_i.reg_wr(`OFS_THRESH_SEL, {1'b0, k[2:0], 4'h7});
					chk_pin("state_low", 2'h1, rx_state);
				end
			end
		end
		chk_pin("rx_empty", 2'h0, rx_state);
		for (n = 128; n >= 1; n--) begin
			if (n <= 64 && n % 8 == 0) begin
				k = n / 8 - 1;
				host_cpu_model_i.reg_wr(`OFS_THRESH_SEL, {5'h00, k[2:0]});
				rd_chk(`OFS_IRQ_STATUS, k == 7 ? 8'h00 : 8'h08, "irq_drain");
				chk_pin("drain_before", 2'h0, {1'b0, drain_f});
			end
			pulse(2'b00, 2'b01);
			if (n <= 64 && n % 8 == 0)
				chk_pin("drain_after", 2'h1, {1'b0, drain_f});
		end
		rd_chk(`OFS_IRQ_STATUS, 8'h08, "irq_drain_last");
		rd_chk(`OFS_IRQ_STATUS, 8'h00, "irq_drain_clr");
		$display("test drain done");
		give_verdict();
	end
endmodule : hdlc_fifo_threshold_and_test_status_tb
`default_nettype wire
